// ---- pbmux_pkg.sv ----
// constants for the port B low pin function multiplexer
package pbmux_pkg;
  // register map (byte address of the only register)
  localparam logic [11:0] SEL_OFFSET = 12'h000;
  localparam logic [31:0] SEL_RESET = 32'h0000_0000;
  // bits 3:0 belong to pins 32 and 33, not held here, read as zero
  localparam logic [31:0] SEL_WRITE_MASK = 32'hFFFF_FFF0;
  localparam logic [31:0] RDATA_IDLE = 32'h0000_0000;

  // field layout: pin (FIRST_PIN + i) uses bits FIELD_LSB+2i+1 : FIELD_LSB+2i
  localparam int FIRST_PIN = 34;
  localparam int NUM_PINS = 14;
  localparam int FIELD_LSB = 4;
  localparam int FIELD_W = 2;

  // function codes
  localparam logic [1:0] CODE_GPIO = 2'h0;
  localparam logic [1:0] CODE_ALT1 = 2'h1;
  localparam logic [1:0] CODE_ALT2 = 2'h2;

  // pin indices inside the 14-pin group
  localparam int IX34 = 0;
  localparam int IX35 = 1;
  localparam int IX36 = 2;
  localparam int IX37 = 3;
  localparam int IX38 = 4;
  localparam int IX39 = 5;
  localparam int IX40 = 6;
  localparam int IX41 = 7;
  localparam int IX47 = 13;

  // second function drives every pin except 34, whose ready is an input
  localparam logic [13:0] ALT2_OE_MASK = 14'h3FFE;

  // APB slave states
  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_ACK = 2'h2
  } pbmux_state_t;
endpackage

// ---- pbmux_top.sv ----
// port B pins 34 to 47 function multiplexer with APB selector register
//
// How it works
// - every field resets to 00; code 00 gives the pin to general I/O
// - bits 31:30 steer pin 47; 01 reserved, 1x drives address line 7
// - bits 29:28 steer pin 46; 01 reserved, 1x drives address line 6
// - bits 27:26 steer pin 45; 01 reserved, 1x drives address line 5
// - bits 25:24 steer pin 44; 01 reserved, 1x drives address line 4
// - bits 23:22 steer pin 43; 01 reserved, 1x drives address line 3
// - bits 21:20 steer pin 42; 01 reserved, 1x drives address line 2
// - bits 19:18 steer pin 41; 01 reserved, 1x drives address line 1
// - bits 17:16 steer pin 40; 1x drives address 0 or write strobe 1
// - bits 15:14 steer pin 39; 01 reserved, 1x drives address line 16
// - bits 13:12 steer pin 38; 01 reserved, 1x drives write strobe 0
// - bits 11:10 steer pin 37; 01 capture 2 both ways, 1x zone 7 select
// - bits 9:8 steer pin 36; 01 serial A receive, 1x zone 0 select
// - bits 7:6 steer pin 35; 01 serial A transmit, 1x read/not-write
// - read/not-write rests high and goes low only while writing
// - bits 5:4 steer pin 34; 01 capture 1 both ways, 1x bus ready in
//
// Implementation choices: the placing of the registers and register access over APB.
module pbmux_top
  import pbmux_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic [13:0] pin_in,
  output logic [13:0] pin_out,
  output logic [13:0] pin_oe,
  input wire logic [13:0] gpio_out,
  input wire logic [13:0] gpio_oe,
  output logic [13:0] gpio_in,
  input wire logic [7:1] ext_bus_addr_lines,
  input wire logic ext_bus_addr0_or_write_strobe1,
  input wire logic ext_bus_addr_line_16,
  input wire logic ext_bus_write_strobe0,
  input wire logic ext_bus_zone7_select,
  input wire logic ext_bus_zone0_select,
  input wire logic ext_bus_write_active,
  output logic ext_bus_ready_input,
  input wire logic serial_a_transmit,
  output logic serial_a_receive,
  input wire logic capture_channel_1_out,
  input wire logic capture_channel_1_oe,
  output logic capture_channel_1_in,
  input wire logic capture_channel_2_out,
  input wire logic capture_channel_2_oe,
  output logic capture_channel_2_in
);

  function automatic logic [1:0] field_of(input logic [31:0] sel, input int i);
    field_of = sel[FIELD_LSB + FIELD_W * i +: FIELD_W];
  endfunction

  // ---------------- APB slave and selector register ----------------
  pbmux_state_t state;
  pbmux_state_t next_state;
  logic [31:0] port_b_low_function_select;
  logic [31:0] next_select;
  logic next_pready;
  logic next_pslverr;
  logic [31:0] next_prdata;
  logic hit;

  always_comb begin
    hit = (paddr == ADDR_W'(SEL_OFFSET));
    next_state = state;
    next_select = port_b_low_function_select;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    next_prdata = RDATA_IDLE;
    unique case (state)
      ST_IDLE: begin
        if (psel && !penable) begin
          next_state = ST_ACK;
          next_pready = 1'b1;
          next_pslverr = !hit;
          if (hit && !pwrite) begin
            next_prdata = port_b_low_function_select & SEL_WRITE_MASK;
          end
        end
      end
      ST_ACK: begin
        next_state = ST_IDLE;
        if (psel && penable && pwrite && hit) begin
          next_select = pwdata & SEL_WRITE_MASK;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      port_b_low_function_select <= SEL_RESET;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= RDATA_IDLE;
    end else begin
      state <= next_state;
      port_b_low_function_select <= next_select;
      pready <= next_pready;
      pslverr <= next_pslverr;
      prdata <= next_prdata;
    end
  end

  // ---------------- pin input synchroniser ----------------
  logic [13:0] pin_meta;
  logic [13:0] pin_sync;
  logic [13:0] next_meta;
  logic [13:0] next_sync;

  always_comb begin
    next_meta = pin_in;
    next_sync = pin_meta;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= next_meta;
      pin_sync <= next_sync;
    end
  end

  // ---------------- function routing ----------------
  logic [13:0] alt1_out;
  logic [13:0] alt1_oe;
  logic [13:0] alt2_out;
  logic [13:0] next_pin_out;
  logic [13:0] next_pin_oe;
  logic [13:0] next_gpio_in;
  logic next_ready;
  logic next_serial_rx;
  logic next_cap1_in;
  logic next_cap2_in;
  logic [1:0] f;

  always_comb begin
    alt1_out = '0;
    alt1_oe = '0;
    alt2_out = '0;
    // first functions; reserved 01 codes leave the pin undriven
    alt1_out[IX34] = capture_channel_1_out;
    alt1_oe[IX34] = capture_channel_1_oe;
    alt1_out[IX35] = serial_a_transmit;
    alt1_oe[IX35] = 1'b1;
    alt1_out[IX37] = capture_channel_2_out;
    alt1_oe[IX37] = capture_channel_2_oe;
    // second functions
    alt2_out[IX47:IX41] = ext_bus_addr_lines;
    alt2_out[IX40] = ext_bus_addr0_or_write_strobe1;
    alt2_out[IX39] = ext_bus_addr_line_16;
    alt2_out[IX38] = ext_bus_write_strobe0;
    alt2_out[IX37] = ext_bus_zone7_select;
    alt2_out[IX36] = ext_bus_zone0_select;
    // high at rest and during reads, low only while a write runs
    alt2_out[IX35] = !ext_bus_write_active;
    next_pin_out = '0;
    next_pin_oe = '0;
    next_gpio_in = '0;
    for (int i = 0; i < NUM_PINS; i++) begin
      f = field_of(port_b_low_function_select, i);
      if (f == CODE_GPIO) begin
        next_pin_out[i] = gpio_out[i];
        next_pin_oe[i] = gpio_oe[i];
        next_gpio_in[i] = pin_sync[i];
      end else if (f == CODE_ALT1) begin
        next_pin_out[i] = alt1_out[i];
        next_pin_oe[i] = alt1_oe[i];
      end else begin
        next_pin_out[i] = alt2_out[i];
        next_pin_oe[i] = ALT2_OE_MASK[i];
      end
    end
    f = field_of(port_b_low_function_select, IX34);
    next_cap1_in = (f == CODE_ALT1) && pin_sync[IX34];
    next_ready = f[1] && pin_sync[IX34];
    f = field_of(port_b_low_function_select, IX36);
    next_serial_rx = (f == CODE_ALT1) && pin_sync[IX36];
    f = field_of(port_b_low_function_select, IX37);
    next_cap2_in = (f == CODE_ALT1) && pin_sync[IX37];
  end

  // outputs are registered, so a reroute shows one edge after the write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_out <= '0;
      pin_oe <= '0;
      gpio_in <= '0;
      ext_bus_ready_input <= 1'b0;
      serial_a_receive <= 1'b0;
      capture_channel_1_in <= 1'b0;
      capture_channel_2_in <= 1'b0;
    end else begin
      pin_out <= next_pin_out;
      pin_oe <= next_pin_oe;
      gpio_in <= next_gpio_in;
      ext_bus_ready_input <= next_ready;
      serial_a_receive <= next_serial_rx;
      capture_channel_1_in <= next_cap1_in;
      capture_channel_2_in <= next_cap2_in;
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic [1:0] f47;
  logic [1:0] f40;
  logic [1:0] f39;
  logic [1:0] f38;
  logic [1:0] f37;
  logic [1:0] f36;
  logic [1:0] f35;
  logic [1:0] f34;
  assign f47 = field_of(port_b_low_function_select, IX47);
  assign f40 = field_of(port_b_low_function_select, IX40);
  assign f39 = field_of(port_b_low_function_select, IX39);
  assign f38 = field_of(port_b_low_function_select, IX38);
  assign f37 = field_of(port_b_low_function_select, IX37);
  assign f36 = field_of(port_b_low_function_select, IX36);
  assign f35 = field_of(port_b_low_function_select, IX35);
  assign f34 = field_of(port_b_low_function_select, IX34);

  sequence s_write_done;
    psel && penable && pready && pwrite && hit;
  endsequence

  sequence s_setup;
    psel && !penable && state == ST_IDLE;
  endsequence

  a_gpio_default_route: assert property (
    f39 == CODE_GPIO |=> pin_oe[IX39] == $past(gpio_oe[IX39])
      && pin_out[IX39] == $past(gpio_out[IX39]))
    else $error("pin 39 not on general I/O under code 00");

  a_addr7_drive: assert property (
    f47[1] |=> pin_oe[IX47] && pin_out[IX47] == $past(ext_bus_addr_lines[7]))
    else $error("pin 47 not driving address line 7");

  a_reserved_quiet: assert property (
    f47 == CODE_ALT1 |=> !pin_oe[IX47])
    else $error("reserved code drives pin 47");

  a_strobe1_drive: assert property (
    f40[1] |=> pin_oe[IX40]
      && pin_out[IX40] == $past(ext_bus_addr0_or_write_strobe1))
    else $error("pin 40 not driving address 0 or strobe 1");

  a_strobe0_drive: assert property (
    f38[1] |=> pin_oe[IX38] && pin_out[IX38] == $past(ext_bus_write_strobe0))
    else $error("pin 38 not driving write strobe 0");

  a_capture2_both: assert property (
    f37 == CODE_ALT1 |=> pin_oe[IX37] == $past(capture_channel_2_oe)
      && pin_out[IX37] == $past(capture_channel_2_out))
    else $error("pin 37 capture output path wrong");

  a_serial_rx_path: assert property (
    f36 == CODE_ALT1 && $stable(f36) |=>
      serial_a_receive == $past(pin_sync[IX36]) && !pin_oe[IX36])
    else $error("pin 36 serial receive path wrong");

  a_serial_tx_drive: assert property (
    f35 == CODE_ALT1 |=> pin_oe[IX35]
      && pin_out[IX35] == $past(serial_a_transmit))
    else $error("pin 35 not driving serial transmit");

  a_rnw_level: assert property (
    f35[1] |=> pin_oe[IX35] && pin_out[IX35] == !$past(ext_bus_write_active))
    else $error("read/not-write level wrong on pin 35");

  a_ready_input: assert property (
    f34[1] |=> !pin_oe[IX34] && ext_bus_ready_input == $past(pin_sync[IX34])
      && !capture_channel_1_in && !gpio_in[IX34])
    else $error("pin 34 ready input path wrong");

  a_unselected_blind: assert property (
    f37 != CODE_ALT1 |=> !capture_channel_2_in)
    else $error("capture 2 sees pin while unselected");

  a_write_reroutes: assert property (
    s_write_done ##1 (field_of(port_b_low_function_select, IX39) == CODE_GPIO)
      |=> pin_oe[IX39] == $past(gpio_oe[IX39]))
    else $error("write did not reroute pin 39");

  a_setup_answer: assert property (
    s_setup |=> pready ##1 !pready)
    else $error("APB answer not one cycle after setup");

  a_write_stores: assert property (
    s_write_done |=>
      port_b_low_function_select == ($past(pwdata) & SEL_WRITE_MASK))
    else $error("selector write not stored");

endmodule

// ---- pbmux_pads.sv ----
// pad model on the far side of the pin mux
module pbmux_pads (
  input wire logic [13:0] pin_out,
  input wire logic [13:0] pin_oe,
  input wire logic [13:0] pad_level,
  output logic [13:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // a driven pad reads back its own drive, others the outside level
  always_comb begin
    for (int i = 0; i < 14; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : pad_level[i];
    end
  end
endmodule

// ---- pbmux_top_test.sv ----
// self-checking bench for the port B low pin function mux
module pbmux_top_test
  import pbmux_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic err;
  logic [13:0] pin_in, pin_out, pin_oe, gpio_out, gpio_oe, gpio_in, pad;
  logic [7:1] addr;
  logic a0, a16, we0, z7, z0, wact, rdy, srx, stx;
  logic c1o, c1e, c1i, c2o, c2e, c2i;
  int num_errors = 0;
  int n_tests = 0;

  always #2 clk = ~clk;

  pbmux_top i_pbmux_top (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .gpio_out(gpio_out),
    .gpio_oe(gpio_oe), .gpio_in(gpio_in), .ext_bus_addr_lines(addr),
    .ext_bus_addr0_or_write_strobe1(a0), .ext_bus_addr_line_16(a16),
    .ext_bus_write_strobe0(we0), .ext_bus_zone7_select(z7),
    .ext_bus_zone0_select(z0), .ext_bus_write_active(wact),
    .ext_bus_ready_input(rdy), .serial_a_transmit(stx),
    .serial_a_receive(srx), .capture_channel_1_out(c1o),
    .capture_channel_1_oe(c1e), .capture_channel_1_in(c1i),
    .capture_channel_2_out(c2o), .capture_channel_2_oe(c2e),
    .capture_channel_2_in(c2i));

  pbmux_pads i_pbmux_pads (.pin_out(pin_out), .pin_oe(pin_oe),
    .pad_level(pad), .pin_in(pin_in));

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // only the watchdog ends a wait that never sees pready
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // pad loop, 2-flop sync and output register; sampled mid-cycle
  task automatic settle;
    repeat (4) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic t_reset;
    apb(1'b0, SEL_OFFSET, 32'h0);
    check("sel reset", rd, SEL_RESET);
    gpio_out <= 14'h1234;
    gpio_oe <= 14'h3FF0;
    settle();
    check("gpio oe", 32'(pin_oe), 32'h3FF0);
    check("gpio out", 32'(pin_out & pin_oe), 32'h1230);
    check("gpio in", 32'(gpio_in), 32'h123D);
    check("periph in", 32'({rdy, srx, c1i, c2i}), 32'h0);
  endtask

  task automatic t_unmapped;
    apb(1'b1, 12'h004, 32'hFFFF_FFFF);
    check("bad wr err", 32'(err), 32'h1);
    apb(1'b0, 12'h004, 32'h0);
    check("bad rd", {rd[30:0], err}, 32'h1);
    apb(1'b0, SEL_OFFSET, 32'h0);
    check("sel kept", rd, SEL_RESET);
  endtask

  task automatic t_bus(input logic [1:0] code);
    apb(1'b1, SEL_OFFSET, {{14{code}}, 4'hF});
    apb(1'b0, SEL_OFFSET, 32'h0);
    check("sel rd", rd, {{14{code}}, 4'h0});
    settle();
    check("bus oe", 32'(pin_oe), 32'(ALT2_OE_MASK));
    check("addr", 32'(pin_out[13:7]), 32'h55);
    check("ctl", 32'(pin_out[6:1]), 32'h2B);
    check("ready", 32'(rdy), 32'h1);
    check("gpio in", 32'(gpio_in), 32'h0);
    @(posedge clk);
    wact <= 1'b1;
    settle();
    check("rnw write", 32'(pin_out[1]), 32'h0);
    @(posedge clk);
    wact <= 1'b0;
    settle();
    check("rnw rest", 32'(pin_out[1]), 32'h1);
  endtask

  task automatic t_alt1;
    apb(1'b1, SEL_OFFSET, 32'h5555_5550);
    settle();
    check("alt1 oe", 32'(pin_oe), 32'h3);
    check("alt1 out", 32'(pin_out[1:0]), 32'h1);
    check("alt1 in", 32'({rdy, srx, c1i, c2i}), 32'h7);
    @(posedge clk);
    stx <= 1'b1;
    c2e <= 1'b1;
    settle();
    check("cap2 oe", 32'(pin_oe), 32'hB);
    check("alt1 drv", 32'(pin_out & pin_oe), 32'h3);
    apb(1'b1, SEL_OFFSET, 32'h0);
    settle();
    check("back gpio", 32'(pin_oe), 32'h3FF0);
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (2000) @(posedge clk);
    num_errors++;
    results();
  end

  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    {gpio_out, gpio_oe, wact, stx, c2o, c2e} = '0;
    {addr, a0, a16, we0, z7, z0} = {7'h55, 5'h15};
    c1o = 1'b1;
    c1e = 1'b1;
    pad = 14'h2A5D;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_unmapped();
    t_bus(2'h2);
    t_bus(2'h3);
    t_alt1();
    results();
  end
endmodule
